// >>> hw/rdl_read_delay_levelization.sv
// Purpose: read data delay levelization control word and latency measurement
// Assumes: register reached by a plain write strobe / read data port from the serial interface
// Notes: everything on the channel clock sys_clk
// Overview of operation
// - The command field of a written word selects which fields that write updates.
// - In levelization mode clocks are counted from an expansion read to the first one on data line five.
// - The read data path is timed from the programmed access latency.
// - The frequency bit selects 300 MHz when 0 and 400 MHz when 1.
// - Outside levelization the expansion delay adds to read delay toward the expansion channel.
// - A field changes only when the written command selects it, except the branch field, which a levelization measurement also loads.
// - In levelization mode the device loads the measured 0 to 7 clock latency into the branch field.
// - The branch delay field steers FIFO loading and the branch-to-expansion mux.
// - The branch field is serially writable outside levelization and read-only inside it.
// - Serial reads return the branch delay field.
// - Command 110 leaves levelization, keeping the last measured branch delay.
`timescale 1ns/1ps
module rdl_read_delay_levelization
	import rdl_pkg::*;
#(
	parameter logic [2:0] TURNAROUND_OFFSET = 3'h1
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// serial register port
	input wire logic reg_write,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	// read path events
	input wire logic exp_read_cmd,
	input wire logic branch_a_data_line_five,
	input wire logic branch_b_data_line_five,
	// read path timing controls
	output logic level_mode,
	output logic freq_400,
	output logic [3:0] data_path_latency,
	output logic [3:0] expansion_total_delay,
	output logic [2:0] fifo_load_delay,
	output logic [2:0] steer_select
);
	// elaboration check on the fixed levelization delay
	generate
		if (TURNAROUND_OFFSET > RDL_LEVEL_BASE) begin : g_offset_check
			$error("turnaround offset exceeds fixed levelization delay");
		end
	endgenerate

	rdl_fields_s fld_reg;
	logic level_reg;
	rdl_meas_e meas_reg;
	logic [2:0] cnt_reg;
	logic [1:0] branch_line;
	wire [1:0] branch_synced;
	logic [2:0] cmd;
	logic hit;
	logic counting;
	logic [2:0] level_delay;
	logic [15:0] rd_word;

	assign cmd = reg_wdata[RDL_CMD_HI:RDL_CMD_LO];
	assign branch_line = {branch_b_data_line_five, branch_a_data_line_five};
	assign hit = |branch_synced;
	assign counting = level_reg && (meas_reg == RDL_COUNT);
	assign level_delay = 3'(RDL_LEVEL_BASE - TURNAROUND_OFFSET);
	assign rd_word = {4'h0, fld_reg.read_access_latency, fld_reg.freq_400,
		fld_reg.expansion_added_delay, 1'b0, fld_reg.measured_branch_delay};

	// two-flop synchroniser per branch data line
	for (genvar ch = 0; ch < 2; ch++) begin : g_sync
		logic [1:0] stage_reg;
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				stage_reg <= 2'h0;
			end else begin
				stage_reg <= {stage_reg[0], branch_line[ch]};
			end
		end
		assign branch_synced[ch] = stage_reg[1];
	end

	// levelization mode
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			level_reg <= 1'b0;
		end else if (reg_write && cmd == RDL_CMD_ENTER) begin
			level_reg <= 1'b1;
		end else if (reg_write && cmd == RDL_CMD_EXIT) begin
			level_reg <= 1'b0;
		end
	end

	// latency measurement
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			meas_reg <= RDL_IDLE;
			cnt_reg <= 3'h0;
		end else if (!level_reg) begin
			meas_reg <= RDL_IDLE;
			cnt_reg <= 3'h0;
		end else begin
			case (meas_reg)
				RDL_IDLE, RDL_DONE: begin
					if (exp_read_cmd) begin
						meas_reg <= RDL_COUNT;
						cnt_reg <= 3'h0;
					end
				end
				RDL_COUNT: begin
					if (hit) begin
						meas_reg <= RDL_DONE;
					end else if (cnt_reg != RDL_BR_MAX) begin
						cnt_reg <= cnt_reg + 3'h1;
					end
				end
				default: meas_reg <= RDL_IDLE;
			endcase
		end
	end

	// latency field
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fld_reg.read_access_latency <= RDL_LAT_RST;
		end else if (reg_write && (cmd == RDL_CMD_LAT || cmd == RDL_CMD_ALL)) begin
			fld_reg.read_access_latency <= reg_wdata[RDL_LAT_HI:RDL_LAT_LO];
		end
	end

	// frequency field
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fld_reg.freq_400 <= 1'b0;
		end else if (reg_write && (cmd == RDL_CMD_FREQ || cmd == RDL_CMD_ALL)) begin
			fld_reg.freq_400 <= reg_wdata[RDL_FREQ_BIT];
		end
	end

	// expansion delay field, writable in either mode
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fld_reg.expansion_added_delay <= 3'h0;
		end else if (reg_write && (cmd == RDL_CMD_EXP || cmd == RDL_CMD_ALL)) begin
			fld_reg.expansion_added_delay <= reg_wdata[RDL_EXP_HI:RDL_EXP_LO];
		end
	end

	// branch delay field: measured in level mode, serial write otherwise
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fld_reg.measured_branch_delay <= 3'h0;
		end else if (counting && hit) begin
			fld_reg.measured_branch_delay <= cnt_reg;
		end else if (counting && cnt_reg == RDL_BR_MAX) begin
			fld_reg.measured_branch_delay <= RDL_BR_MAX;
		end else if (!level_reg && reg_write && (cmd == RDL_CMD_BR || cmd == RDL_CMD_ALL)) begin
			fld_reg.measured_branch_delay <= reg_wdata[RDL_BR_HI:RDL_BR_LO];
		end
	end

	// serial readback word
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= RDL_WORD_RST;
		end else begin
			reg_rdata <= rd_word;
		end
	end

	// mode, rate and access latency toward the read path
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			level_mode <= 1'b0;
			freq_400 <= 1'b0;
			data_path_latency <= RDL_LAT_RST;
		end else begin
			level_mode <= level_reg;
			freq_400 <= fld_reg.freq_400;
			data_path_latency <= fld_reg.read_access_latency;
		end
	end

	// delay toward the expansion channel
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			expansion_total_delay <= 4'h0;
		end else if (level_reg) begin
			expansion_total_delay <= {1'b0, level_delay};
		end else begin
			expansion_total_delay <= {1'b0, fld_reg.expansion_added_delay};
		end
	end

	// fifo loading and steering mux select
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fifo_load_delay <= 3'h0;
			steer_select <= 3'h0;
		end else begin
			fifo_load_delay <= fld_reg.measured_branch_delay;
			steer_select <= fld_reg.measured_branch_delay;
		end
	end
endmodule

// >>> hw/rdl_pkg.sv
// Purpose: shared constants and types for read delay levelization control
// Assumes: channel clock domain only
// Notes: field positions follow the 16-bit control word
package rdl_pkg;
	localparam int RDL_CMD_HI = 14;
	localparam int RDL_CMD_LO = 12;
	localparam int RDL_LAT_HI = 11;
	localparam int RDL_LAT_LO = 8;
	localparam int RDL_FREQ_BIT = 7;
	localparam int RDL_EXP_HI = 6;
	localparam int RDL_EXP_LO = 4;
	localparam int RDL_BR_HI = 2;
	localparam int RDL_BR_LO = 0;
	localparam logic [2:0] RDL_CMD_NOP = 3'h0;
	localparam logic [2:0] RDL_CMD_LAT = 3'h1;
	localparam logic [2:0] RDL_CMD_EXP = 3'h2;
	localparam logic [2:0] RDL_CMD_BR = 3'h3;
	localparam logic [2:0] RDL_CMD_FREQ = 3'h4;
	localparam logic [2:0] RDL_CMD_ALL = 3'h5;
	localparam logic [2:0] RDL_CMD_EXIT = 3'h6;
	localparam logic [2:0] RDL_CMD_ENTER = 3'h7;
	localparam logic [3:0] RDL_LAT_RST = 4'h4;
	localparam logic [2:0] RDL_BR_MAX = 3'h7;
	localparam logic [2:0] RDL_LEVEL_BASE = 3'h3;
	localparam logic [15:0] RDL_WORD_RST = 16'h0400;
	typedef struct packed {
		logic [3:0] read_access_latency;
		logic freq_400;
		logic [2:0] expansion_added_delay;
		logic [2:0] measured_branch_delay;
	} rdl_fields_s;
	typedef enum logic [1:0] {RDL_IDLE, RDL_COUNT, RDL_DONE} rdl_meas_e;
endpackage

// >>> verification/rdl_props.sv
// Purpose: rdl port checks
// Assumes: one clock
// Notes: bound in tb
`timescale 1ns/1ps
module rdl_props #(
	parameter logic [2:0] TURNAROUND_OFFSET = 3'h1
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// serial register port
	input wire logic reg_write,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	// read path timing controls
	input wire logic level_mode,
	input wire logic freq_400,
	input wire logic [3:0] data_path_latency,
	input wire logic [3:0] expansion_total_delay,
	input wire logic [2:0] fifo_load_delay,
	input wire logic [2:0] steer_select
);
	wire [2:0] c = reg_wdata[14:12];
	wire w = reg_write;
	wire lat_wr = w && (c == 3'h1 || c == 3'h5);
	wire enter_wr = w && c == 3'h7;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_lat_write: assert property (w && c inside {1, 5} |-> ##2
		data_path_latency == $past(reg_wdata[11:8], 2)) else $error("latency");
	a_freq_write: assert property (w && c inside {4, 5} |-> ##2
		freq_400 == $past(reg_wdata[7], 2)) else $error("freq");
	a_lat_hold: assert property (w && !lat_wr && !$past(lat_wr) |-> ##2
		$stable(data_path_latency)) else $error("hold");
	a_br_write: assert property (w && !level_mode && !$past(enter_wr) && c inside {3, 5} |-> ##2
		steer_select == $past(reg_wdata[2:0], 2)) else $error("branch");
	a_fifo_steer: assert property (fifo_load_delay == steer_select) else $error("fifo");
	a_enter_mode: assert property (w && c == 7 |-> ##2 level_mode) else $error("enter");
	a_exit_mode: assert property (w && c == 6 |-> ##2 !level_mode) else $error("exit");
	a_fixed_delay: assert property (level_mode |->
		expansion_total_delay == 3'h3 - TURNAROUND_OFFSET) else $error("fixed");
	a_steer_read: assert property (steer_select == reg_rdata[2:0]) else $error("steer");
	cover property (w && c == 7);
	cover property (w && c == 6);
	cover property (level_mode && steer_select == 7);
endmodule

// >>> verification/rdl_branch_model.sv
// Purpose: far branch device answering reads
// Assumes: one clock of one on line five, lag clocks on
// Notes: line idles low
`timescale 1ns/1ps
module rdl_branch_model (
	// channel side
	input wire logic sys_clk, exp_read_cmd,
	input wire logic [3:0] lag,
	output logic line
);
	int cnt = 99;
	always @(posedge sys_clk) cnt <= exp_read_cmd ? 0 : (cnt < 99 ? cnt + 1 : 99);
	assign line = cnt == int'(lag);
endmodule

// >>> verification/tb.sv
// Purpose: rdl bench
// Assumes: model plays far branch device
// Notes: inputs move at negedge
`timescale 1ns/1ps
module tb;
	logic sys_clk = 0, rst = 1, reg_write = 0, exp_read_cmd = 0, line_a, line_b, use_b = 0;
	logic level_mode, freq_400;
	logic [15:0] reg_wdata = 0, reg_rdata;
	logic [3:0] data_path_latency, expansion_total_delay, lag = 0, lag_b = 0;
	logic [2:0] fifo_load_delay, steer_select;
	int fail_count = 0, checks_done = 0;
	always #4 sys_clk = ~sys_clk;
	rdl_read_delay_levelization dut_u (
		.sys_clk(sys_clk), .rst(rst), .reg_write(reg_write), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .exp_read_cmd(exp_read_cmd),
		.branch_a_data_line_five(line_a), .branch_b_data_line_five(line_b),
		.level_mode(level_mode), .freq_400(freq_400), .data_path_latency(data_path_latency),
		.expansion_total_delay(expansion_total_delay), .fifo_load_delay(fifo_load_delay),
		.steer_select(steer_select));
	rdl_branch_model br_a_u (.sys_clk(sys_clk), .exp_read_cmd(exp_read_cmd & !use_b),
		.lag(lag), .line(line_a));
	rdl_branch_model br_b_u (.sys_clk(sys_clk), .exp_read_cmd(exp_read_cmd & use_b),
		.lag(lag_b), .line(line_b));
	task automatic chk(input string n, input logic [15:0] e, g);
		checks_done++;
		if (g !== e) fail_count++;
		if (g !== e) $display("mismatch %s exp %h got %h", n, e, g);
	endtask
	task automatic wr(input logic [15:0] d, e);
		@(negedge sys_clk) reg_write = 1;
		reg_wdata = d;
		@(negedge sys_clk) reg_write = 0;
		@(negedge sys_clk);
		chk("rdata", e, reg_rdata);
	endtask
	task automatic t_fields();
		logic [15:0] w[6] = '{16'h1500, 16'h29ff, 16'h4080, 16'h0fff, 16'h3005, 16'h5956};
		logic [15:0] e[6] = '{16'h0500, 16'h0570, 16'h05f0, 16'h05f0, 16'h05f5, 16'h0956};
		for (int i = 0; i < 6; i++) wr(w[i], e[i]);
		chk("exp delay", 4'h5, expansion_total_delay);
		chk("fifo", 3'h6, fifo_load_delay);
		chk("latency", 4'h9, data_path_latency);
		chk("freq", 1'b0, freq_400);
		$display("fields done");
	endtask
	task automatic t_meas();
		wr(16'h7000, 16'h0956);
		wr(16'h3001, 16'h0956);
		chk("fixed", 4'h2, expansion_total_delay);
		chk("mode", 1'b1, level_mode);
		for (int i = 0; i < 4; i++) begin
			use_b = (i == 3);
			lag = 4'(i * 3 + 2);
			lag_b = 4'h1;
			@(negedge sys_clk) exp_read_cmd = 1;
			@(negedge sys_clk) exp_read_cmd = 0;
			repeat (14) @(negedge sys_clk);
			chk("measured", i == 3 ? 3 : (i ? 7 : 4), steer_select);
		end
		wr(16'h6000, 16'h0953);
		chk("mode", 1'b0, level_mode);
		chk("exp after exit", 4'h5, expansion_total_delay);
		chk("fifo", 3'h3, fifo_load_delay);
		$display("level done");
	endtask
	initial begin
		#40 rst = 0;
		t_fields();
		t_meas();
		stop_test();
	end
	initial begin
		#20000 fail_count++;
		stop_test();
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
endmodule
bind rdl_read_delay_levelization rdl_props #(.TURNAROUND_OFFSET(TURNAROUND_OFFSET)) p_u (
	.sys_clk(sys_clk), .rst(rst), .reg_write(reg_write), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .level_mode(level_mode), .freq_400(freq_400),
	.data_path_latency(data_path_latency), .expansion_total_delay(expansion_total_delay),
	.fifo_load_delay(fifo_load_delay), .steer_select(steer_select));
